// ==== include/pfss_map.vh ====
// Constants for the paper feed stepper sequencer
`ifndef PFSS_MAP_VH
`define PFSS_MAP_VH

// Clock and timing
`define PFSS_CLK_MHZ        20
`define PFSS_US_PER_S       1000000
`define PFSS_PPS_FULL       3200
`define PFSS_PPS_REDUCED    2720
`define PFSS_PPS_LOAD       320
`define PFSS_STOP_HOLD_US   20000

// Feed geometry
`define PFSS_STEPS_PER_MM   16
`define PFSS_LOAD_SLOW_MM   300
`define PFSS_STEPS_PER_LINE 2

// Acceleration table shape
`define PFSS_TBL_LAST       48
`define PFSS_TAIL_DEC_US    7
`define PFSS_RAMP_MAX       127

// Phase patterns of step states 1..4 as {phase_in_a, phase_in_b}
`define PFSS_PAT_STEP1      2'b11
`define PFSS_PAT_STEP2      2'b01
`define PFSS_PAT_STEP3      2'b00
`define PFSS_PAT_STEP4      2'b10

`endif

// ==== verilog/pfss_step_timer.v ====
// Down counter that times one step state
`default_nettype none

module pfss_step_timer (
	input  wire        clk_i,
	input  wire        srst_i,
	input  wire        load_i,
	input  wire [23:0] count_i,
	output wire        done_o
);

	reg [23:0] cnt;

	always @(posedge clk_i) begin
		if (srst_i) begin
			cnt <= 24'h00_0000;
		end else if (load_i) begin
			cnt <= count_i;
		end else if (cnt != 24'h00_0000) begin
			cnt <= cnt - 24'h00_0001;
		end
	end

	// Pulses in the last cycle of the loaded period
	assign done_o = (cnt == 24'h00_0001);

endmodule

`default_nettype wire

// ==== verilog/pfss_sequencer.v ====
// Paper feed stepper sequencer driving a bipolar chopper motor driver
`include "pfss_map.vh"
`default_nettype none

module pfss_sequencer #(
	parameter integer CYC_PER_US = `PFSS_CLK_MHZ
) (
	input  wire        clk_i,
	input  wire        srst_i,
	input  wire        feed_start_i,
	input  wire [23:0] feed_steps_i,
	input  wire        autoload_i,
	input  wire        reduced_rate_i,
	output wire        start_ready_o,
	output wire        busy_o,
	output wire        print_allow_o,
	output reg         at_speed_o,
	output reg         step_o,
	output reg         dot_line_o,
	output reg  [23:0] steps_done_o,
	output reg  [22:0] dot_lines_o,
	output reg         phase_in_a_o,
	output reg         phase_in_b_o,
	output reg         phase_in_c_o,
	output reg         phase_in_d_o,
	output reg         motor_drive_enable_line_o
);

	////////////////////////////////////////////////////////////////////////
	// Timing counts

	localparam integer CYC_PER_S = CYC_PER_US * `PFSS_US_PER_S;
	localparam integer CYC_FULL_I =
		(CYC_PER_S + `PFSS_PPS_FULL - 1) / `PFSS_PPS_FULL;
	localparam integer CYC_RED_I =
		(CYC_PER_S + `PFSS_PPS_REDUCED - 1) / `PFSS_PPS_REDUCED;
	localparam integer CYC_LOAD_I =
		(CYC_PER_S + `PFSS_PPS_LOAD - 1) / `PFSS_PPS_LOAD;
	localparam integer CYC_STOP_I = `PFSS_STOP_HOLD_US * CYC_PER_US;
	localparam integer LOAD_STEPS_I =
		`PFSS_LOAD_SLOW_MM * `PFSS_STEPS_PER_MM;
	localparam integer RAMP_MAX_I = `PFSS_RAMP_MAX;
	localparam integer TBL_LAST_I = `PFSS_TBL_LAST;
	localparam integer TAIL_DEC_I = `PFSS_TAIL_DEC_US;

	localparam [23:0] CYC_FULL   = CYC_FULL_I[23:0];
	localparam [23:0] CYC_RED    = CYC_RED_I[23:0];
	localparam [23:0] CYC_LOAD   = CYC_LOAD_I[23:0];
	localparam [23:0] CYC_STOP   = CYC_STOP_I[23:0];
	localparam [23:0] LOAD_STEPS = LOAD_STEPS_I[23:0];
	localparam [6:0]  RAMP_MAX   = RAMP_MAX_I[6:0];
	localparam [6:0]  TBL_LAST   = TBL_LAST_I[6:0];
	localparam [12:0] TAIL_DEC   = TAIL_DEC_I[12:0];

	////////////////////////////////////////////////////////////////////////
	// States

	localparam [3:0] ST_PAUSE = 4'b0001;
	localparam [3:0] ST_START = 4'b0010;
	localparam [3:0] ST_RUN   = 4'b0100;
	localparam [3:0] ST_STOPH = 4'b1000;

	////////////////////////////////////////////////////////////////////////
	// Acceleration table in microseconds

	function [12:0] accel_us;
		input [6:0] idx;
		begin
			case (idx)
			7'd0:    accel_us = 13'd5653;
			7'd1:    accel_us = 13'd5653;
			7'd2:    accel_us = 13'd3494;
			7'd3:    accel_us = 13'd2698;
			7'd4:    accel_us = 13'd2265;
			7'd5:    accel_us = 13'd1986;
			7'd6:    accel_us = 13'd1787;
			7'd7:    accel_us = 13'd1637;
			7'd8:    accel_us = 13'd1519;
			7'd9:    accel_us = 13'd1423;
			7'd10:   accel_us = 13'd1343;
			7'd11:   accel_us = 13'd1274;
			7'd12:   accel_us = 13'd1215;
			7'd13:   accel_us = 13'd1164;
			7'd14:   accel_us = 13'd1118;
			7'd15:   accel_us = 13'd1078;
			7'd16:   accel_us = 13'd1041;
			7'd17:   accel_us = 13'd1008;
			7'd18:   accel_us = 13'd977;
			7'd19:   accel_us = 13'd948;
			7'd20:   accel_us = 13'd922;
			7'd21:   accel_us = 13'd901;
			7'd22:   accel_us = 13'd880;
			7'd23:   accel_us = 13'd861;
			7'd24:   accel_us = 13'd843;
			7'd25:   accel_us = 13'd826;
			7'd26:   accel_us = 13'd810;
			7'd27:   accel_us = 13'd795;
			7'd28:   accel_us = 13'd781;
			7'd29:   accel_us = 13'd767;
			7'd30:   accel_us = 13'd748;
			7'd31:   accel_us = 13'd735;
			7'd32:   accel_us = 13'd723;
			7'd33:   accel_us = 13'd712;
			7'd34:   accel_us = 13'd701;
			7'd35:   accel_us = 13'd690;
			7'd36:   accel_us = 13'd680;
			7'd37:   accel_us = 13'd671;
			7'd38:   accel_us = 13'd662;
			7'd39:   accel_us = 13'd653;
			7'd40:   accel_us = 13'd644;
			7'd41:   accel_us = 13'd636;
			7'd42:   accel_us = 13'd628;
			7'd43:   accel_us = 13'd621;
			7'd44:   accel_us = 13'd613;
			7'd45:   accel_us = 13'd606;
			7'd46:   accel_us = 13'd599;
			7'd47:   accel_us = 13'd593;
			7'd48:   accel_us = 13'd586;
			default: accel_us = 13'd0;
			endcase
		end
	endfunction

	// Table time in cycles; past the table the time keeps shrinking
	function [23:0] accel_cyc;
		input [6:0] idx;
		reg   [12:0] us;
		reg   [12:0] dec;
		reg   [31:0] prod;
		begin
			dec = 13'd0;
			us  = accel_us(idx);
			if (idx > TBL_LAST) begin
				dec = TAIL_DEC * {6'd0, idx - TBL_LAST};
				us  = (dec < accel_us(TBL_LAST)) ?
					accel_us(TBL_LAST) - dec : 13'd0;
			end
			prod = {19'd0, us} * CYC_PER_US;
			accel_cyc = prod[23:0];
		end
	endfunction

	// Step time never shorter than the present rate limit
	function [23:0] step_cyc;
		input [6:0]  idx;
		input [23:0] lim;
		reg   [23:0] t;
		begin
			t = accel_cyc(idx);
			step_cyc = (t > lim) ? t : lim;
		end
	endfunction

	// Phase pattern of a step state index 0..3
	function [1:0] pattern;
		input [1:0] ph;
		begin
			case (ph)
			2'd0:    pattern = `PFSS_PAT_STEP1;
			2'd1:    pattern = `PFSS_PAT_STEP2;
			2'd2:    pattern = `PFSS_PAT_STEP3;
			2'd3:    pattern = `PFSS_PAT_STEP4;
			default: pattern = `PFSS_PAT_STEP1;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	reg  [3:0]  state;
	reg  [1:0]  ph;
	reg  [6:0]  ridx;
	reg  [23:0] target;
	reg         auto;
	reg  [3:0]  next_state;
	reg  [1:0]  next_ph;
	reg  [6:0]  next_ridx;
	reg  [23:0] next_target;
	reg         next_auto;
	reg  [23:0] next_done;
	reg  [22:0] next_lines;
	reg         next_step;
	reg         next_line;
	reg         load;
	reg  [23:0] load_val;
	reg  [23:0] limit;
	reg  [6:0]  adv_idx;
	reg  [1:0]  pat;
	reg         next_on;
	wire        tdone;
	wire        go;

	assign start_ready_o = (state == ST_PAUSE) || (state == ST_STOPH);
	assign go = feed_start_i && start_ready_o
		&& (feed_steps_i != 24'h00_0000);
	assign busy_o = (state != ST_PAUSE);
	assign print_allow_o = (state == ST_RUN);

	pfss_step_timer u_timer (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.load_i  (load),
		.count_i (load_val),
		.done_o  (tdone)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always @* begin
		next_state  = state;
		next_ph     = ph;
		next_ridx   = ridx;
		next_target = target;
		next_auto   = auto;
		next_done   = steps_done_o;
		next_lines  = dot_lines_o;
		next_step   = 1'b0;
		next_line   = 1'b0;
		load        = 1'b0;
		load_val    = 24'h00_0000;
		// Slow rate during the first part of an auto-load
		if (auto && (steps_done_o < LOAD_STEPS)) begin
			limit = CYC_LOAD;
		end else if (reduced_rate_i) begin
			limit = CYC_RED;
		end else begin
			limit = CYC_FULL;
		end
		// Ramp advances only while slower than the limit
		adv_idx = ((accel_cyc(ridx) > limit) && (ridx != RAMP_MAX)) ?
			ridx + 7'd1 : ridx;
		case (state)
		ST_PAUSE: begin
			if (go) begin
				next_target = feed_steps_i;
				next_auto   = autoload_i;
				next_done   = 24'h00_0000;
				next_lines  = 23'h00_0000;
				next_ridx   = 7'd0;
				load        = 1'b1;
				load_val    = accel_cyc(7'd0);
				next_state  = ST_START;
			end
		end
		ST_START: begin
			if (tdone) begin
				next_ph    = ph + 2'd1;
				next_ridx  = 7'd1;
				load       = 1'b1;
				load_val   = step_cyc(7'd1, limit);
				next_state = ST_RUN;
			end
		end
		ST_RUN: begin
			if (tdone) begin
				next_done = steps_done_o + 24'h00_0001;
				next_step = 1'b1;
				if (steps_done_o[0]) begin
					next_line  = 1'b1;
					next_lines = dot_lines_o + 23'h00_0001;
				end
				if (next_done == target) begin
					load       = 1'b1;
					load_val   = CYC_STOP;
					next_state = ST_STOPH;
				end else begin
					next_ph   = ph + 2'd1;
					next_ridx = adv_idx;
					load      = 1'b1;
					load_val  = step_cyc(adv_idx, limit);
				end
			end
		end
		ST_STOPH: begin
			if (go) begin
				next_target = feed_steps_i;
				next_auto   = autoload_i;
				next_done   = 24'h00_0000;
				next_lines  = 23'h00_0000;
				next_ph     = ph + 2'd1;
				next_ridx   = 7'd1;
				load        = 1'b1;
				load_val    = step_cyc(7'd1, CYC_FULL);
				next_state  = ST_RUN;
			end else if (tdone) begin
				next_state = ST_PAUSE;
			end
		end
		default: begin
			next_state = ST_PAUSE;
		end
		endcase
		next_on = (next_state != ST_PAUSE);
		pat = pattern(next_ph);
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and pins

	always @(posedge clk_i) begin
		if (srst_i) begin
			state                     <= ST_PAUSE;
			ph                        <= 2'd0;
			ridx                      <= 7'd0;
			target                    <= 24'h00_0000;
			auto                      <= 1'b0;
			steps_done_o              <= 24'h00_0000;
			dot_lines_o               <= 23'h00_0000;
			step_o                    <= 1'b0;
			dot_line_o                <= 1'b0;
			at_speed_o                <= 1'b0;
			phase_in_a_o              <= 1'b0;
			phase_in_b_o              <= 1'b0;
			phase_in_c_o              <= 1'b0;
			phase_in_d_o              <= 1'b0;
			motor_drive_enable_line_o <= 1'b0;
		end else begin
			state        <= next_state;
			ph           <= next_ph;
			ridx         <= next_ridx;
			target       <= next_target;
			auto         <= next_auto;
			steps_done_o <= next_done;
			dot_lines_o  <= next_lines;
			step_o       <= next_step;
			dot_line_o   <= next_line;
			at_speed_o   <= (next_state == ST_RUN) && load
				&& (load_val == limit);
			// Windings off in pause, pattern held otherwise
			phase_in_a_o <= next_on & pat[1];
			phase_in_b_o <= next_on & pat[0];
			phase_in_c_o <= 1'b0;
			phase_in_d_o <= 1'b0;
			motor_drive_enable_line_o <= next_on;
		end
	end

endmodule

`default_nettype wire

// ==== tb/pfss_sequencer_chk.sv ====
// Port checker for the paper feed stepper sequencer
`default_nettype none
module pfss_chk #(
	parameter integer CYC_PER_US = 20
) (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        feed_start_i,
	input wire logic [23:0] feed_steps_i,
	input wire logic        start_ready_o,
	input wire logic        busy_o,
	input wire logic        step_o,
	input wire logic        dot_line_o,
	input wire logic [23:0] steps_done_o,
	input wire logic        phase_in_a_o,
	input wire logic        phase_in_b_o,
	input wire logic        phase_in_c_o,
	input wire logic        phase_in_d_o,
	input wire logic        motor_drive_enable_line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIM = (CYC_PER_US * 1000000 + 3199) / 3200;
	localparam int STOP = 20000 * CYC_PER_US;
	logic [31:0] gap;
	always_ff @(posedge clk_i) begin
		if (srst_i || step_o)
			gap <= '0;
		else
			gap <= gap + 32'h0000_0001;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_cd_low: assert property (!phase_in_c_o && !phase_in_d_o)
		else $error("c or d phase driven");
	a_enable_busy: assert property (
		motor_drive_enable_line_o == busy_o) else $error("enable off");
	a_pause_off: assert property (
		!busy_o |-> !phase_in_a_o && !phase_in_b_o) else $error("excited");
	a_phase_order: assert property (
		motor_drive_enable_line_o && $past(motor_drive_enable_line_o)
		&& $changed({phase_in_a_o, phase_in_b_o}) |->
		{phase_in_a_o, phase_in_b_o} == {!$past(phase_in_b_o),
		$past(phase_in_a_o)}) else $error("phase order");
	a_start_taken: assert property (
		feed_start_i && start_ready_o && feed_steps_i != 0 |=>
		busy_o && !start_ready_o) else $error("start lost");
	a_dot_pair: assert property (
		dot_line_o |-> step_o && !steps_done_o[0]) else $error("dot line");
	a_rate_cap: assert property (
		step_o |-> gap >= LIM - 1) else $error("step too fast");
	a_stop_hold: assert property (
		$fell(motor_drive_enable_line_o) |-> gap == STOP - 1)
		else $error("stop hold length");
endmodule
bind pfss_sequencer pfss_chk #(.CYC_PER_US(CYC_PER_US)) chk (.clk_i,
	.srst_i, .feed_start_i, .feed_steps_i, .start_ready_o, .busy_o,
	.step_o, .dot_line_o, .steps_done_o, .phase_in_a_o, .phase_in_b_o,
	.phase_in_c_o, .phase_in_d_o, .motor_drive_enable_line_o);
`default_nettype wire

// ==== tb/pfss_motor_model.sv ====
// Behavioural feed motor behind a bipolar chopper driver
`default_nettype none
module pfss_motor_model (
	input  wire logic clk_i,
	input  wire logic phase_in_a_i,
	input  wire logic phase_in_b_i,
	input  wire logic phase_in_c_i,
	input  wire logic phase_in_d_i,
	input  wire logic enable_i,
	output var  int   position_o,
	output var  logic fault_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] last = 2'h3;
	initial position_o = 0;
	initial fault_o = 1'b0;
	always @(posedge clk_i) begin
		// Rotor moves only while driven; unexcited it rests
		if (enable_i && {phase_in_a_i, phase_in_b_i} != last) begin
			// One 1/16 mm step per forward state
			if ({phase_in_a_i, phase_in_b_i} == {!last[0], last[1]})
				position_o <= position_o + 1;
			else
				fault_o <= 1'b1;
		end
		if (enable_i)
			last <= {phase_in_a_i, phase_in_b_i};
		// Pins c and d unused in forward feed
		if (phase_in_c_i || phase_in_d_i)
			fault_o <= 1'b1;
	end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench of the paper feed stepper sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, start = 0, aload = 0, slow = 0;
	logic [23:0] steps = '0, done;
	logic [22:0] lines;
	logic ready, busy, pallow, atspd, step, dline, a, b, c, d, en, fault;
	int pos, n, num_errors = 0, total_checks = 0, cycles = 0;
	always #25 clk = ~clk;
	pfss_sequencer #(.CYC_PER_US(1)) dut (.clk_i(clk), .srst_i(srst),
		.feed_start_i(start), .feed_steps_i(steps), .autoload_i(aload),
		.reduced_rate_i(slow), .start_ready_o(ready), .busy_o(busy),
		.print_allow_o(pallow), .at_speed_o(atspd), .step_o(step),
		.dot_line_o(dline), .steps_done_o(done), .dot_lines_o(lines),
		.phase_in_a_o(a), .phase_in_b_o(b), .phase_in_c_o(c),
		.phase_in_d_o(d), .motor_drive_enable_line_o(en));
	pfss_motor_model motor (.clk_i(clk), .phase_in_a_i(a),
		.phase_in_b_i(b), .phase_in_c_i(c), .phase_in_d_i(d),
		.enable_i(en), .position_o(pos), .fault_o(fault));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Cycles until the phase pins change
	task automatic measure(output int k);
		logic [1:0] p;
		p = {a, b};
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while ({a, b} == p && k < 40000);
	endtask
	task automatic start_feed(input logic [23:0] s, input logic al);
		@(posedge clk);
		start <= 1'b1;
		steps <= s;
		aload <= al;
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
	endtask
	task automatic reset_values();
		check(32'({ready, busy, en, a, b}), 32'h0000_0010);
		check(32'({pallow, atspd}), 32'h0000_0000);
	endtask
	task automatic pause_start();
		start_feed(24'h00_0003, 1'b0);
		check(32'({busy, en, a, b}), 32'h0000_000f);
		check(32'(pallow), 32'h0000_0000);
		measure(n);
		check(n, 32'h0000_1615);
		check(32'({pallow, atspd}), 32'h0000_0002);
		measure(n);
		check(n, 32'h0000_1615);
		measure(n);
		check(n, 32'h0000_0da6);
		check(32'({a, b}), 32'h0000_0002);
		check(32'(atspd), 32'h0000_0000);
		measure(n);
		check(n, 32'h0000_58aa);
		check(32'({en, pallow}), 32'h0000_0000);
		check(32'(done), 32'h0000_0003);
		check(32'(lines), 32'h0000_0001);
		check(pos, 32'h0000_0003);
	endtask
	task automatic autoload_restart();
		@(posedge clk);
		slow <= 1'b1;
		start_feed(24'h00_0003, 1'b1);
		check(32'({a, b}), 32'h0000_0002);
		measure(n);
		measure(n);
		measure(n);
		check(n, 32'h0000_0da6);
		check(32'(atspd), 32'h0000_0001);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!step && n < 40000);
		check(n, 32'h0000_0c35);
		check(32'(ready), 32'h0000_0001);
		start_feed(24'h00_0001, 1'b0);
		check(32'({a, b, pallow}), 32'h0000_0005);
		measure(n);
		check(n, 32'h0000_6435);
		check(32'(done), 32'h0000_0001);
		check(32'({fault, en}), 32'h0000_0000);
		check(pos, 32'h0000_0007);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		reset_values();
		pause_start();
		autoload_restart();
		print_verdict();
	end
endmodule
`default_nettype wire
